// ==== src/spi_frame_port.v ====
// Purpose: serial slave frame port with a receive word fifo
// Assumes: serial clock far slower than ref_clk (4+ samples per phase)
// Notes: captured frames leave through a fifo; reply words enter by port
`timescale 1ns/100ps
`include "spi_frame_regs.vh"

module word_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             ref_clk,   // clock
  input  wire             reset,     // async reset, high
  input  wire [WIDTH-1:0] in_data,   // write word
  input  wire             in_valid,  // write request
  output wire             in_ready,  // room left
  output reg  [WIDTH-1:0] out_data,  // head word
  output reg              out_valid, // head present
  input  wire             out_ready  // consumer takes head
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire [AW:0]     held;
  wire            push;
  wire            pop;

  // ----------------------------------------------------------------
  // occupancy
  // ----------------------------------------------------------------
  // the head register counts as a slot, so DEPTH words fill it exactly
  assign held     = count + {{AW{1'b0}}, out_valid};
  assign push     = in_valid && in_ready;
  assign pop      = (!out_valid || out_ready) && (count != {(AW+1){1'b0}});
  assign in_ready = (held != DEPTH[AW:0]);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------

  always @(posedge ref_clk) begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  // ----------------------------------------------------------------
  // pointers and head register
  // ----------------------------------------------------------------
  // head register refills whenever empty or taken
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_ptr    <= {AW{1'b0}};
      rd_ptr    <= {AW{1'b0}};
      count     <= {(AW+1){1'b0}};
      out_data  <= {WIDTH{1'b0}};
      out_valid <= 1'b0;
    end else begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop) begin
        rd_ptr   <= rd_ptr + 1'b1;
        out_data <= mem[rd_ptr];
      end
      if (pop)
        out_valid <= 1'b1;
      else if (out_ready)
        out_valid <= 1'b0;
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // word_fifo

// ----------------------------------------------------------------
// pin synchroniser
// ----------------------------------------------------------------
// three flops per pin; only the second and its delayed copy feed logic
module pin_sync #(
  parameter IDLE = 1'b0
) (
  input  wire ref_clk, // clock
  input  wire reset,   // async reset, high
  input  wire pin,     // raw pin level
  output wire level,   // synchronised level
  output wire rise,    // level went high
  output wire fall     // level went low
);
  reg meta;
  reg stable;
  reg last;

  // reset to the idle level so no false edge follows reset
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      meta   <= IDLE;
      stable <= IDLE;
      last   <= IDLE;
    end else begin
      meta   <= pin;
      stable <= meta;
      last   <= stable;
    end
  end

  assign level = stable;
  assign rise  = stable && !last;
  assign fall  = !stable && last;
endmodule // pin_sync

// ----------------------------------------------------------------
// frame port
// ----------------------------------------------------------------
// limitation: reply_word is sampled once, when selection is seen
module spi_frame_port #(
  parameter DEPTH = `FIFO_DEPTH
) (
  input  wire        ref_clk,          // 10 MHz system clock
  input  wire        reset,            // async reset, high
  input  wire        serial_clk,       // serial clock pin
  input  wire        serial_data_in,   // serial data pin
  input  wire        chip_select_n,    // select pin, low active
  output reg         serial_data_out,  // data out level
  output reg         serial_data_oe_n, // out enable, low drives
  input  wire [15:0] reply_word,       // next reply from core
  output wire        reply_taken,      // reply loaded, pulse
  output wire [6:0]  frame_addr,       // head frame address
  output wire        frame_access,     // head frame access bit
  output wire [7:0]  frame_data,       // head frame data byte
  output wire        frame_valid,      // head frame present
  input  wire        frame_ready,      // core takes frame
  output reg         frame_error,      // last frame bad clock count
  output reg         frame_dropped     // frame lost, fifo full
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire csn_level;
  wire selected;
  wire sel_fall;
  wire sel_rise;
  wire sclk_rise;
  wire sclk_fall;
  wire sdi_level;

  // select idles high; clock and data idle low
  pin_sync #(
    .IDLE (1'b1)
  ) csn_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pin     (chip_select_n),
    .level   (csn_level),
    .rise    (sel_rise),
    .fall    (sel_fall)
  );

  pin_sync #(
    .IDLE (1'b0)
  ) sclk_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pin     (serial_clk),
    .level   (),
    .rise    (sclk_rise),
    .fall    (sclk_fall)
  );

  // data needs no edges, only its level at a clock fall
  pin_sync #(
    .IDLE (1'b0)
  ) sdi_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pin     (serial_data_in),
    .level   (sdi_level),
    .rise    (),
    .fall    ()
  );

  assign selected = !csn_level;

  // ----------------------------------------------------------------
  // frame capture
  // ----------------------------------------------------------------
  reg [`FRAME_BITS-1:0] in_shift;
  reg [`FRAME_BITS-1:0] out_shift;
  reg [`CNT_BITS-1:0]   bit_count;
  reg                   err_pending;
  wire                  fifo_in_ready;
  wire [15:0]           head_word;
  wire                  count_ok;
  wire                  good_frame;

  // a frame with no clocks is legal: it only fetches the reply
  assign count_ok    = (bit_count == `CNT_NONE) || (bit_count == `CNT_FULL);
  // decode at release; drops bad counts
  assign good_frame  = sel_rise && (bit_count == `CNT_FULL);
  assign reply_taken = sel_fall;

  // ----------------------------------------------------------------
  // clock counter
  // ----------------------------------------------------------------
  // saturates so a long burst never wraps back to a legal count
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bit_count <= `CNT_NONE;
    end else begin
      if (sel_fall) begin
        bit_count <= `CNT_NONE;
      end else if (selected && sclk_fall && bit_count != `CNT_MAX) begin
        bit_count <= bit_count + `CNT_STEP;
      end
    end
  end

  // ----------------------------------------------------------------
  // input shift register
  // ----------------------------------------------------------------
  // sample on falling clock
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      in_shift <= `FRAME_CLEAR;
    end else begin
      if (selected && !sel_fall && sclk_fall)
        in_shift <= {in_shift[14:0], sdi_level};
    end
  end

  // ----------------------------------------------------------------
  // output shift register
  // ----------------------------------------------------------------
  // first bit is set up at selection, so the first rising clock keeps it
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      out_shift        <= `FRAME_CLEAR;
      serial_data_out  <= 1'b0;
      serial_data_oe_n <= 1'b1;
    end else begin
      if (sel_fall) begin
        serial_data_oe_n <= 1'b0;
        out_shift        <= {reply_word[14:0], 1'b0};
        serial_data_out  <= reply_word[`ERR_BIT] | err_pending;
      end else if (selected && sclk_rise && bit_count != `CNT_NONE) begin
        serial_data_out <= out_shift[15];
        out_shift       <= {out_shift[14:0], 1'b0};
      end
      if (sel_rise)
        serial_data_oe_n <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // frame status flags
  // ----------------------------------------------------------------
  // flags move only at release, so they describe the last frame
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      err_pending   <= 1'b0;
      frame_error   <= 1'b0;
      frame_dropped <= 1'b0;
    end else begin
      // remember bad count for next reply
      if (sel_rise) begin
        err_pending   <= !count_ok;
        frame_error   <= !count_ok;
        frame_dropped <= good_frame && !fifo_in_ready;
      end
    end
  end

  // ----------------------------------------------------------------
  // received frame buffer
  // ----------------------------------------------------------------
  // pointers wrap freely, so DEPTH must be a power of two
  word_fifo #(
    .WIDTH (`FRAME_BITS),
    .DEPTH (DEPTH),
    .AW    ($clog2(DEPTH))
  ) rx_fifo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_data   (in_shift),
    .in_valid  (good_frame),
    .in_ready  (fifo_in_ready),
    .out_data  (head_word),
    .out_valid (frame_valid),
    .out_ready (frame_ready)
  );

  // ----------------------------------------------------------------
  // head word fields
  // ----------------------------------------------------------------
  // low seven bits address
  assign frame_addr   = head_word[`ADDR_MSB:`ADDR_LSB];
  assign frame_access = head_word[`ACCESS_BIT];
  assign frame_data   = head_word[`DATA_MSB:`DATA_LSB];
endmodule // spi_frame_port

// ==== src/spi_frame_regs.vh ====
// Purpose: constants for the serial frame port
// Assumes: 16-bit frames, address in low bits, data byte in high bits
// Notes: clock counts are in serial clock falls, not ref_clk cycles
//
// Notes on behaviour
// - master clocks in a 16-bit word
// - nothing shifts before chip select falls
// - decode captured word at select release
// - output released when select rises
// - sample input on falling serial clock
// - shift output after rising serial clock
// - no daisy chain, own select needed
// - clock count not 0/16 flags error
// - low seven bits are register address
// - bit seven picks access variant
// - upper byte carries data
`ifndef SPI_FRAME_REGS_VH
`define SPI_FRAME_REGS_VH
`define FRAME_BITS      16
`define CNT_BITS        5
`define ADDR_LSB        0
`define ADDR_MSB        6
`define ACCESS_BIT      7
`define DATA_LSB        8
`define DATA_MSB        15
`define FIFO_DEPTH      16
`define ERR_BIT         15
`define CNT_NONE        5'h00
`define CNT_FULL        5'h10
`define CNT_MAX         5'h1f
`define CNT_STEP        5'h01
`define FRAME_CLEAR     16'h0000
`endif

// ==== sim/spi_frame_monitor.sv ====
// Purpose: port checks for the serial frame port
// Assumes: pins pass a 3 cycle synchroniser
// Notes: bound into every spi_frame_port
`timescale 1ns/100ps
module spi_frame_monitor (
  input wire logic       ref_clk,          // clock
  input wire logic       reset,            // reset
  input wire logic       serial_clk,       // link clock
  input wire logic       chip_select_n,    // select
  input wire logic       serial_data_out,  // data out
  input wire logic       serial_data_oe_n, // out enable
  input wire logic       reply_taken,      // reply load
  input wire logic [6:0] frame_addr,       // head addr
  input wire logic       frame_access,     // head access
  input wire logic [7:0] frame_data,       // head data
  input wire logic       frame_valid,      // head present
  input wire logic       frame_ready,      // head taken
  input wire logic       frame_error,      // count fault
  input wire logic       frame_dropped     // frame lost
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence idle_sel;
    chip_select_n [*8];
  endsequence
  sequence low_drive;
    (!serial_clk && !serial_data_oe_n) [*4];
  endsequence
  release_on_cs_a: assert property ($rose(chip_select_n) |-> ##[1:6] serial_data_oe_n)
    else $error("output not released");
  idle_hiz_a: assert property (idle_sel |-> serial_data_oe_n)
    else $error("output driven while idle");
  select_drive_a: assert property ($fell(chip_select_n) |-> ##[2:6] !serial_data_oe_n)
    else $error("output not driven after select");
  shift_hold_a: assert property (low_drive |-> $stable(serial_data_out))
    else $error("output moved in clock low phase");
  err_first_a: assert property ($fell(serial_data_oe_n) && frame_error |-> serial_data_out)
    else $error("error bit not shown");
  drop_full_a: assert property ($rose(frame_dropped) |-> frame_valid)
    else $error("drop with room left");
  head_hold_a: assert property (frame_valid && !frame_ready |=> frame_valid &&
    $stable({frame_addr, frame_access, frame_data}))
    else $error("head changed before taken");
  reply_load_a: assert property (reply_taken |-> !chip_select_n ##1 !reply_taken)
    else $error("reply load out of frame");
endmodule // spi_frame_monitor
bind spi_frame_port spi_frame_monitor mon (.*);

// ==== sim/spi_master_model.sv ====
// Purpose: host side master of the frame port
// Assumes: 800 ns link clock, idle low
// Notes: released data line shows the inverse level
`timescale 1ns/100ps
module spi_master_model (
  input  wire logic serial_data_out, // device output
  input  wire logic serial_data_oe_n, // device out enable
  output logic      serial_clk,      // link clock
  output logic      serial_data_in,  // device input
  output logic      chip_select_n    // select, low active
);
  initial begin
    serial_clk = 1'b0;
    serial_data_in = 1'b0;
    chip_select_n = 1'b1;
  end
  // released line reads as the inverse, so a late drive shows up
  wire logic sdo_line;
  assign sdo_line = serial_data_oe_n ? ~serial_data_out : serial_data_out;
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    chip_select_n = 1'b0;
    #800;
    for (int i = 0; i < n; i++) begin
      // data moves with the rising clock, half a period before sampling
      #400 serial_clk = 1'b1;
      serial_data_in = w[15 - i];
      #400 serial_clk = 1'b0;
      r = {r[14:0], sdo_line};
    end
    #400 chip_select_n = 1'b1;
    serial_data_in = ~serial_data_in;
    #800;
  endtask
  task automatic stray();
    repeat (3) begin
      #400 serial_clk = 1'b1;
      #400 serial_clk = 1'b0;
    end
    // clock rests low before the next selection
    #400;
  endtask
endmodule // spi_master_model

// ==== sim/tb_top.sv ====
// Purpose: frame port bench
// Assumes: 10 MHz ref_clk
// Notes: fifo filled past full, then drained
`timescale 1ns/100ps
module tb_top;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic frame_ready = 1'b0;
  logic [15:0] reply_word = 16'h5a3c;
  logic [15:0] r;
  wire serial_clk, serial_data_in, chip_select_n, serial_data_out, serial_data_oe_n;
  wire reply_taken, frame_access, frame_valid, frame_error, frame_dropped;
  wire [6:0] frame_addr;
  wire [7:0] frame_data;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  initial forever #50 ref_clk = ~ref_clk;
  spi_frame_port dut (.*);
  spi_master_model m (.*);
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  function automatic logic [15:0] wd(input int i);
    return {8'(i * 37), i[0], 7'(i + 3)};
  endfunction
  task automatic settle();
    repeat (10) @(posedge ref_clk);
    #1;
  endtask
  task automatic pop(input logic [15:0] exp);
    repeat (20) if (frame_valid !== 1'b1) @(posedge ref_clk) #1;
    chk("head", {frame_data, frame_access, frame_addr}, exp);
    frame_ready = 1'b1;
    @(posedge ref_clk) #1 frame_ready = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic t_fill();
    for (int i = 0; i < 17; i++) begin
      m.xfer(wd(i), 16, r);
      chk("reply", r, reply_word);
    end
    settle();
    chk("dropped", 16'(frame_dropped), 16'h0001);
    for (int i = 0; i < 16; i++) pop(wd(i));
    chk("empty", 16'(frame_valid), 16'h0000);
    $display("test fill done");
  endtask
  task automatic t_err();
    m.stray();
    m.xfer(wd(1), 8, r);
    settle();
    chk("err", 16'(frame_error), 16'h0001);
    chk("discard", 16'(frame_valid), 16'h0000);
    m.stray();
    m.xfer(wd(2), 16, r);
    chk("flag", r, reply_word | 16'h8000);
    m.xfer(wd(3), 0, r);
    settle();
    chk("zero", 16'(frame_error), 16'h0000);
    pop(wd(2));
    chk("zero gone", 16'(frame_valid), 16'h0000);
    $display("test error done");
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    #1 reset = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    t_fill();
    t_err();
    end_sim();
  end
  // hang guard, run needs about 2950 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 8000) begin
      error_cnt++;
      end_sim();
    end
  end
endmodule // tb_top
